// >>> logic/cdi_gpio_trig.sv
`default_nettype none
module cdi_gpio_trig
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Trigger link to the register block
  cdi_trig_if.det   trig_if
);
  import cdi_pkg::*;

  logic prev_reg;

  // Last sampled pin level, basis of edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= 1'b0;
    else if (ce)
      prev_reg <= trig_if.pin_level;
  end

  // Trigger condition; only an input-configured pin may fire
  always_comb
  begin
    trig_if.hit = 1'b0;
    if (trig_if.setup == CDI_SETUP_INPUT)
    begin
      case (trig_if.trig)
        CDI_TRIG_NEG_LEVEL: trig_if.hit = !trig_if.pin_level;
        CDI_TRIG_POS_EDGE:  trig_if.hit = trig_if.pin_level && !prev_reg;
        CDI_TRIG_NEG_EDGE:  trig_if.hit = !trig_if.pin_level && prev_reg;
        CDI_TRIG_POS_LEVEL: trig_if.hit = trig_if.pin_level;
        default:            trig_if.hit = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/cdi_irq_top.sv
// Functional notes
// - Enabled stage completion asserts interrupt, bit=stage
// - Cleared stage enable blocks that completion
// - Bit 12 enables GPIO change interrupt
// - Enable register at 0x007, RW, resets zero
// - GPIO interrupt only when setup is input
// - Trigger field selects level or edge condition
// - Threshold flags clear on read unless exceeded
`default_nettype none
module cdi_irq_top
#(
  parameter int NSTAGE = 12
)
(
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  // Converter events
  input  wire logic [NSTAGE-1:0] stage_done,
  input  wire logic [NSTAGE-1:0] low_exceed,
  input  wire logic [NSTAGE-1:0] high_exceed,
  // General-purpose pin
  input  wire logic              gpio_i,
  output logic                   gpio_o,
  output logic                   gpio_oe,
  // Interrupt line
  output logic                   int_n
);
  import cdi_pkg::*;

  logic [NSTAGE-1:0] stage_done_irq_en_bit_reg;
  logic              gpio_irq_en_reg;
  logic [NSTAGE-1:0] low_irq_en_reg;
  logic [1:0]        gpio_setup_reg;
  logic [1:0]        gpio_trig_reg;
  logic [NSTAGE-1:0] below_limit_flag_reg;
  logic [NSTAGE-1:0] above_limit_flag_reg;
  logic [NSTAGE-1:0] done_pend_reg;
  logic              gpio_pend_reg;
  logic [31:0]       prdata_reg;
  logic              int_n_reg;
  logic              gpio_o_reg;
  logic              gpio_oe_reg;
  logic [7:0]        idx;
  logic              aligned;
  logic              mapped;
  logic              setup_ph;
  logic              access;
  logic              wr;
  logic              rd;
  logic [31:0]       rd_next;

  cdi_trig_if trig_if ();

  // Trigger detector sees the pin and its configuration
  assign trig_if.pin_level = gpio_i;
  assign trig_if.setup     = gpio_setup_reg;
  assign trig_if.trig      = gpio_trig_reg;

  cdi_gpio_trig u_trig
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .trig_if (trig_if)
  );

  // Address decode; printed offsets are word indices
  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign mapped   = aligned && ((idx == CDI_IDX_LOW_EN_GPIO) || (idx == CDI_IDX_DONE_EN) ||
                    (idx == CDI_IDX_LOW_FLAG) || (idx == CDI_IDX_HIGH_FLAG) ||
                    (idx == CDI_IDX_EVENT));
  assign setup_ph = psel && !penable && ce;
  assign access   = psel && penable && ce;
  assign wr       = access && pwrite && mapped;
  assign rd       = access && !pwrite && mapped;

  // One wait-free access phase; read data is captured in setup so it comes from a flop
  assign pready  = psel && penable && ce;
  assign pslverr = psel && penable && ce && !mapped;
  assign prdata  = prdata_reg;

  // Read mux, unused bits read as zero
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (idx)
      CDI_IDX_LOW_EN_GPIO:
      begin
        rd_next[NSTAGE-1:0]                     = low_irq_en_reg;
        rd_next[CDI_POS_GPIO_SETUP+:2]          = gpio_setup_reg;
        rd_next[CDI_POS_GPIO_TRIG+:2]           = gpio_trig_reg;
      end
      CDI_IDX_DONE_EN:
      begin
        rd_next[NSTAGE-1:0]                     = stage_done_irq_en_bit_reg;
        rd_next[CDI_POS_GPIO_IRQ_EN]            = gpio_irq_en_reg;
      end
      CDI_IDX_LOW_FLAG:  rd_next[NSTAGE-1:0]    = below_limit_flag_reg;
      CDI_IDX_HIGH_FLAG: rd_next[NSTAGE-1:0]    = above_limit_flag_reg;
      CDI_IDX_EVENT:
      begin
        rd_next[NSTAGE-1:0]                     = done_pend_reg;
        rd_next[CDI_POS_GPIO_IRQ_EN]            = gpio_pend_reg;
      end
      default:           rd_next                = 32'h0000_0000;
    endcase
    if (!aligned)
      rd_next = 32'h0000_0000;
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (setup_ph)
      prdata_reg <= rd_next;
  end

  // Completion enable register; bits 15:13 are dropped, host keeps them zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_done_irq_en_bit_reg <= CDI_RST_REG[NSTAGE-1:0];
      gpio_irq_en_reg           <= CDI_RST_REG[CDI_POS_GPIO_IRQ_EN];
    end
    else if (wr && (idx == CDI_IDX_DONE_EN))
    begin
      stage_done_irq_en_bit_reg <= pwdata[NSTAGE-1:0];
      gpio_irq_en_reg           <= pwdata[CDI_POS_GPIO_IRQ_EN];
    end
  end

  // Low enables and GPIO configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_irq_en_reg <= CDI_RST_REG[NSTAGE-1:0];
      gpio_setup_reg <= CDI_RST_REG[CDI_POS_GPIO_SETUP+:2];
      gpio_trig_reg  <= CDI_RST_REG[CDI_POS_GPIO_TRIG+:2];
    end
    else if (wr && (idx == CDI_IDX_LOW_EN_GPIO))
    begin
      low_irq_en_reg <= pwdata[NSTAGE-1:0];
      gpio_setup_reg <= pwdata[CDI_POS_GPIO_SETUP+:2];
      gpio_trig_reg  <= pwdata[CDI_POS_GPIO_TRIG+:2];
    end
  end

  // Threshold flags: a read clears only those whose limit is no longer exceeded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      below_limit_flag_reg <= CDI_RST_REG[NSTAGE-1:0];
      above_limit_flag_reg <= CDI_RST_REG[NSTAGE-1:0];
    end
    else if (ce)
    begin
      below_limit_flag_reg <= ((rd && (idx == CDI_IDX_LOW_FLAG)) ? {NSTAGE{1'b0}} :
                               below_limit_flag_reg) | low_exceed;
      above_limit_flag_reg <= ((rd && (idx == CDI_IDX_HIGH_FLAG)) ? {NSTAGE{1'b0}} :
                               above_limit_flag_reg) | high_exceed;
    end
  end

  // Pending events; a new event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_pend_reg <= CDI_RST_REG[NSTAGE-1:0];
      gpio_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      done_pend_reg <= ((rd && (idx == CDI_IDX_EVENT)) ? {NSTAGE{1'b0}} : done_pend_reg) |
                       (stage_done & stage_done_irq_en_bit_reg);
      gpio_pend_reg <= ((rd && (idx == CDI_IDX_EVENT)) ? 1'b0 : gpio_pend_reg) |
                       (trig_if.hit && gpio_irq_en_reg);
    end
  end

  // Interrupt line; masking again here lets a disable withdraw a waiting request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_n_reg <= 1'b1;
    else if (ce)
      int_n_reg <= !(|(done_pend_reg & stage_done_irq_en_bit_reg) ||
                     (gpio_pend_reg && gpio_irq_en_reg));
  end
  assign int_n = int_n_reg;

  // Output setups drive the pin at the level they name, low for CDI_SETUP_OUT_LOW and high for CDI_SETUP_OUT_HIGH
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gpio_oe_reg <= 1'b0;
      gpio_o_reg  <= 1'b0;
    end
    else if (ce)
    begin
      gpio_oe_reg <= (gpio_setup_reg == CDI_SETUP_OUT_LOW) ||
                     (gpio_setup_reg == CDI_SETUP_OUT_HIGH);
      gpio_o_reg  <= (gpio_setup_reg == CDI_SETUP_OUT_HIGH);
    end
  end
  assign gpio_oe = gpio_oe_reg;
  assign gpio_o  = gpio_o_reg;
endmodule
`default_nettype wire

// >>> logic/cdi_pkg.sv
`default_nettype none
package cdi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  CDI_IDX_LOW_EN_GPIO = 8'h05;
  localparam logic [7:0]  CDI_IDX_DONE_EN     = 8'h07;
  localparam logic [7:0]  CDI_IDX_LOW_FLAG    = 8'h08;
  localparam logic [7:0]  CDI_IDX_HIGH_FLAG   = 8'h09;
  localparam logic [7:0]  CDI_IDX_EVENT       = 8'h0b;
  localparam int          CDI_NUM_STAGES      = 12;
  // Field positions
  localparam int          CDI_POS_GPIO_IRQ_EN = 12;
  localparam int          CDI_POS_GPIO_SETUP  = 12;
  localparam int          CDI_POS_GPIO_TRIG   = 14;
  // Values after reset
  localparam logic [15:0] CDI_RST_REG         = 16'h0000;
  // GPIO setup encodings
  localparam logic [1:0]  CDI_SETUP_OFF       = 2'h0;
  localparam logic [1:0]  CDI_SETUP_INPUT     = 2'h1;
  localparam logic [1:0]  CDI_SETUP_OUT_LOW   = 2'h2;
  localparam logic [1:0]  CDI_SETUP_OUT_HIGH  = 2'h3;
  // GPIO input trigger encodings
  localparam logic [1:0]  CDI_TRIG_NEG_LEVEL  = 2'h0;
  localparam logic [1:0]  CDI_TRIG_POS_EDGE   = 2'h1;
  localparam logic [1:0]  CDI_TRIG_NEG_EDGE   = 2'h2;
  localparam logic [1:0]  CDI_TRIG_POS_LEVEL  = 2'h3;
endpackage
`default_nettype wire

// >>> logic/cdi_trig_if.sv
`default_nettype none
interface cdi_trig_if;
  logic       pin_level;
  logic [1:0] setup;
  logic [1:0] trig;
  logic       hit;
  modport ctrl (output pin_level, output setup, output trig, input hit);
  modport det  (input pin_level, input setup, input trig, output hit);
endinterface
`default_nettype wire

// >>> test/cdi_irq_monitor.sv
`default_nettype none
module cdi_irq_monitor #(
  parameter int NSTAGE = 12
)
(
  // Clock and control
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  // Events and interrupt
  input wire logic [NSTAGE-1:0] stage_done,
  input wire logic              int_n
);
  logic [NSTAGE:0] en_sh;
  wire  logic      acc = psel && penable && ce;
  wire  logic      wr_en = acc && pwrite && paddr == 12'h01c;
  wire  logic      clr = wr_en || (acc && paddr == 12'h02c);
  // Shadow of the enable register, since the checker sees only the ports
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) en_sh <= '0;
    else if (wr_en) en_sh <= pwdata[NSTAGE:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready == ce; endproperty
  a_ready: assert property (p_ready) else $error("pready missing");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  property p_align; pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
  a_align: assert property (p_align) else $error("misaligned not refused");
  property p_unmap; pready && paddr[11:10] != 2'h0 |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_back; pready && !pwrite && paddr == 12'h01c |-> prdata == 32'(en_sh); endproperty
  a_back: assert property (p_back) else $error("enable readback wrong");
  // Stage event with enable set pulls the line low two edges later
  property p_done; ce && !wr_en && |(stage_done & en_sh[NSTAGE-1:0]) ##1 ce && !wr_en
    |=> !int_n; endproperty
  a_done: assert property (p_done) else $error("enabled stage gave no irq");
  property p_off; $fell(int_n) |-> $past(en_sh) != '0; endproperty
  a_off: assert property (p_off) else $error("irq with no source enabled");
  // Only an access to the event register (read or write) or an enable write may withdraw the line
  property p_stand; !int_n && !$past(clr) |=> !int_n; endproperty
  a_stand: assert property (p_stand) else $error("irq dropped by itself");
endmodule
bind cdi_irq_top cdi_irq_monitor #(.NSTAGE(NSTAGE)) mon (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .stage_done, .int_n);
`default_nettype wire

// >>> test/test_conversion_done_irq_enable.sv
`default_nettype none
module test_conversion_done_irq_enable;
  timeunit 1ns;
  timeprecision 1ps;
  import cdi_pkg::*;
  localparam logic [11:0] A_EN = 12'(CDI_IDX_DONE_EN) << 2;
  localparam logic [11:0] A_CFG = 12'(CDI_IDX_LOW_EN_GPIO) << 2;
  localparam logic [11:0] A_EV = 12'(CDI_IDX_EVENT) << 2;
  localparam logic [11:0] A_LO = 12'(CDI_IDX_LOW_FLAG) << 2;
  localparam logic [11:0] A_HI = 12'(CDI_IDX_HIGH_FLAG) << 2;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gpio_i = 0, ce = 1;
  logic [11:0] paddr = '0, stage_done = '0, low_exceed = '0, high_exceed = '0, lo, hi;
  logic [31:0] pwdata = '0, rd, prdata, cfg, rnd = 32'ha869d17c;
  logic        pready, pslverr, err, int_n, gpio_o, gpio_oe;
  logic [12:0] en;
  int          bad_count = 0, n_checks = 0;
  // Threshold inputs only feed the sticky flags; they never reach the interrupt line
  cdi_irq_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .stage_done(stage_done), .low_exceed(low_exceed),
    .high_exceed(high_exceed), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .int_n(int_n));
  always #2 pclk = ~pclk;
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // One APB transfer; a dead slave is caught by the watchdog, not here
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // The whole run needs under a thousand cycles; this span leaves ample margin
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
  // All, none, then random enables; every stage pulsed once per setting
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, A_EN, 0, rd, err);
    chk("enable reset", 0, rd);
    for (int k = 0; k < 6; k++)
    begin
      en = (k == 0) ? 13'h0fff : (k == 1) ? 13'h0 : 13'(xs());
      apb(1, A_EN, {19'h0, en}, rd, err);
      apb(1, A_EN + 12'h2, xs(), rd, err);
      chk("misaligned error", 1, err);
      apb(0, A_EN, 0, rd, err);
      chk("enable readback", 32'(en), rd);
      for (int i = 0; i < 12; i++)
      begin
        stage_done[i] <= 1;
        @(posedge pclk);
        stage_done[i] <= 0;
        repeat (2) @(posedge pclk);
        #1 chk("stage int_n", !en[i], int_n);
        apb(0, A_EV, 0, rd, err);
        chk("stage pending", 32'(en[i]) << i, rd);
      end
    end
    apb(0, 12'h3fc, 0, rd, err);
    chk("unmapped error", 1, err);
    // Each trigger mode from its idle level, then setup off must stay silent
    apb(1, A_EN, 32'h1000, rd, err);
    for (int k = 0; k < 5; k++)
    begin
      gpio_i <= !k[0];
      cfg = {16'h0, k[1:0], (k < 4) ? CDI_SETUP_INPUT : CDI_SETUP_OFF, 12'h0};
      apb(1, A_CFG, cfg, rd, err);
      apb(0, A_CFG, 0, rd, err);
      chk("config readback", cfg, rd);
      apb(0, A_EV, 0, rd, err);
      gpio_i <= k[0];
      repeat (3) @(posedge pclk);
      #1 chk("gpio int_n", 32'(k == 4), int_n);
      chk("gpio oe", 0, gpio_oe);
    end
    // Driven setups put their level on the pin one edge after the write
    for (int s = 2; s < 4; s++)
    begin
      apb(1, A_CFG, 32'(s) << CDI_POS_GPIO_SETUP, rd, err);
      @(posedge pclk);
      #1 chk("gpio oe", 1, gpio_oe);
      chk("gpio out", 32'(s == 3), gpio_o);
    end
    // Sticky limit flags; a read keeps only those whose limit is still exceeded
    for (int k = 0; k < 4; k++)
    begin
      lo = 12'(xs());
      hi = 12'(xs());
      @(posedge pclk);
      low_exceed <= lo;
      high_exceed <= hi;
      @(posedge pclk);
      low_exceed <= lo & hi;
      high_exceed <= lo & hi;
      apb(0, A_LO, 0, rd, err);
      chk("low flags", 32'(lo), rd);
      apb(0, A_HI, 0, rd, err);
      chk("high flags", 32'(hi), rd);
      low_exceed <= '0;
      high_exceed <= '0;
      apb(0, A_LO, 0, rd, err);
      chk("low flags kept", 32'(lo & hi), rd);
      apb(0, A_HI, 0, rd, err);
      chk("high flags kept", 32'(lo & hi), rd);
      apb(0, A_LO, 0, rd, err);
      chk("low flags cleared", 0, rd);
    end
    // Clock enable low freezes the event path; the event lands once ce returns
    apb(1, A_EN, 32'h0001, rd, err);
    ce <= 0;
    stage_done[0] <= 1;
    repeat (3) @(posedge pclk);
    ce <= 1;
    #1 chk("frozen int_n", 1, int_n);
    @(posedge pclk);
    stage_done[0] <= 0;
    repeat (2) @(posedge pclk);
    #1 chk("resumed int_n", 0, int_n);
    // Reset in mid-run with the line asserted; enables and pending return to zero
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    #1 chk("reset int_n", 1, int_n);
    apb(0, A_EN, 0, rd, err);
    chk("enable after reset", 0, rd);
    apb(0, A_EV, 0, rd, err);
    chk("pending after reset", 0, rd);
    finish_test();
  end
endmodule
`default_nettype wire
